//--- hw/hk_adc_ctrl.sv
// Housekeeping converter control: temperature and battery conversions,
// background scheduling, delta and threshold checks, result registers.
// Assumes converters and power-state controller run on sys_clk.
// Operation
// - Temperature result is an 8-bit code of 0.83 degC per step.
// - Temperature start bit launches one conversion; completion interrupts with result loaded.
// - Background temperature conversions off after reset; run only with nonzero interval.
// - Background temperature interrupts when difference from last interrupting code exceeds delta.
// - Full-power mode allows single and background conversions on both channels.
// - Battery-active mode: temperature only from single start, no background.
// - Sleep measure mode: temperature only from background scheduler.
// - Temperature result loads only when a temperature interrupt is raised.
// - Temperature interrupt has no readable status flag.
// - Battery result is an 8-bit code of 14.6 mV per step.
// - Battery start bit launches one conversion; completion sets the low-battery flag with result loaded.
// - Background battery conversions recur at the battery interval field rate.
// - Battery code below threshold sets the low-battery flag.
// - Low-battery flag drives power interrupt only while its enable is set.
// - A finished single battery conversion also sets the low-battery flag.
// - Battery-active mode: battery only from single start, no background.
// - Sleep measure mode: no battery conversion at all.
// - Battery result loads only when the low-battery flag becomes set.
// - Each start bit clears itself once the converter accepts the request.
// - Temperature interval codes: off, 8, 2 and 1 minutes.
// - Delta codes: none, one to six steps, or every conversion.
`timescale 1ns/1ps
`default_nettype none
module hk_adc_ctrl
    import hk_pkg::*;
#(
    parameter logic [31:0] MINUTE_CYCLES = HK_MINUTE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] power_mode,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic batt_conv_req,
    input wire logic batt_conv_ack,
    input wire logic batt_conv_done,
    input wire logic [7:0] batt_conv_code,
    output logic temp_conv_req,
    input wire logic temp_conv_ack,
    input wire logic temp_conv_done,
    input wire logic [7:0] temp_conv_code,
    input wire logic ext_result_load,
    input wire logic [7:0] ext_result_code,
    output logic temp_irq,
    output logic power_supply_monitor_irq
);

    ////////////////////////////////////////////////////////////////////////
    hk_sched_if sif ();

    hk_sched #(
        .MINUTE_CYCLES(MINUTE_CYCLES)
    ) u_sched (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Software-visible registers.
    logic [1:0] start_q, start_d;
    logic [3:0] strobe_q, strobe_d;
    logic [5:0] delta_q, delta_d;
    logic [7:0] thr_q, thr_d;
    logic low_batt_flag_q, low_batt_flag_d;
    logic low_batt_enable_q, low_batt_enable_d;
    logic [7:0] temperature_result_q, temperature_result_d;
    logic [7:0] battery_result_q, battery_result_d;
    logic [7:0] ext_voltage_result_q, ext_voltage_result_d;
    logic [7:0] last_temp_q, last_temp_d;
    logic temp_irq_q, temp_irq_d;
    logic [7:0] rdata_q, rdata_d;

    logic [1:0] conv_ack, conv_done, conv_req, accept_single, fin, fin_single;
    logic [1:0] single_ok, bg_ok;
    logic [7:0] conv_code [2];
    logic [2:0] temp_delta_field;
    logic [8:0] temp_sub;
    logic [7:0] temp_abs;
    logic temp_fire, batt_set;

    assign conv_ack = {temp_conv_ack, batt_conv_ack};
    assign conv_done = {temp_conv_done, batt_conv_done};
    assign conv_code[HK_CH_BATT] = batt_conv_code;
    assign conv_code[HK_CH_TEMP] = temp_conv_code;
    assign batt_conv_req = conv_req[HK_CH_BATT];
    assign temp_conv_req = conv_req[HK_CH_TEMP];
    assign sif.sel[HK_CH_TEMP] = strobe_q[HK_TEMP_SEL_LSB +: 2];
    assign sif.sel[HK_CH_BATT] = strobe_q[HK_BATT_SEL_LSB +: 2];
    assign temp_delta_field = delta_q[HK_DELTA_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Which start sources each power mode admits.
    always_comb begin
        single_ok = 2'b00;
        bg_ok = 2'b00;
        case (hk_mode_t'(power_mode))
            HK_MODE_FULL: begin
                single_ok = 2'b11;
                bg_ok = 2'b11;
            end
            HK_MODE_BATT: begin
                single_ok = 2'b11;
                bg_ok = 2'b00;
            end
            HK_MODE_SLEEP: begin
                single_ok = 2'b00;
                bg_ok = 2'b10;
            end
            default: begin
                single_ok = 2'b00;
                bg_ok = 2'b00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // One request/accept/done sequencer per converter.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        hk_cstate_t st_q, st_d;
        logic single_q, single_d;
        logic bg_q, bg_d;

        // A background slot that falls due during a busy or barred period is
        // kept only if the mode admits it; it is served once when idle.
        always_comb begin
            st_d = st_q;
            single_d = single_q;
            bg_d = bg_q | (sif.due[c] & bg_ok[c]);
            case (st_q)
                HK_IDLE: begin
                    if (start_q[c] && single_ok[c]) begin
                        st_d = HK_REQ;
                        single_d = 1'b1;
                    end else if (bg_q && bg_ok[c]) begin
                        st_d = HK_REQ;
                        single_d = 1'b0;
                        bg_d = sif.due[c] & bg_ok[c];
                    end
                end
                HK_REQ: begin
                    if (conv_ack[c]) begin
                        st_d = HK_WAIT;
                    end
                end
                HK_WAIT: begin
                    if (conv_done[c]) begin
                        st_d = HK_IDLE;
                    end
                end
                default: begin
                    st_d = HK_IDLE;
                end
            endcase
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                st_q <= HK_IDLE;
                single_q <= 1'b0;
                bg_q <= 1'b0;
            end else begin
                st_q <= st_d;
                single_q <= single_d;
                bg_q <= bg_d;
            end
        end

        assign conv_req[c] = (st_q == HK_REQ);
        assign accept_single[c] = (st_q == HK_REQ) && conv_ack[c] && single_q;
        assign fin[c] = (st_q == HK_WAIT) && conv_done[c];
        assign fin_single[c] = single_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result evaluation and register updates.
    always_comb begin
        temp_sub = {1'b0, conv_code[HK_CH_TEMP]} - {1'b0, last_temp_q};
        temp_abs = temp_sub[8] ? 8'(~temp_sub[7:0] + 8'h1) : temp_sub[7:0];
        temp_fire = fin[HK_CH_TEMP] && (fin_single[HK_CH_TEMP] ||
            (temp_delta_field == HK_DELTA_ALL) ||
            ((temp_delta_field != HK_DELTA_OFF) && (temp_abs > 8'(temp_delta_field))));
        batt_set = fin[HK_CH_BATT] && (fin_single[HK_CH_BATT] ||
            (conv_code[HK_CH_BATT] < thr_q));
    end

    always_comb begin
        start_d = start_q & ~accept_single;
        strobe_d = strobe_q;
        delta_d = delta_q;
        thr_d = thr_q;
        low_batt_enable_d = low_batt_enable_q;
        low_batt_flag_d = low_batt_flag_q;
        if (sfr_wr) begin
            case (sfr_addr)
                HK_ADDR_START: start_d = start_d | sfr_wdata[1:0];
                HK_ADDR_STROBE: strobe_d = sfr_wdata[3:0];
                HK_ADDR_DELTA: delta_d = sfr_wdata[5:0];
                HK_ADDR_BATT_THR: thr_d = sfr_wdata;
                HK_ADDR_PWR_ENABLE: low_batt_enable_d = sfr_wdata[HK_BIT_LOW_BATT];
                HK_ADDR_PWR_FLAG: begin
                    if (!sfr_wdata[HK_BIT_LOW_BATT]) begin
                        low_batt_flag_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A threshold event in the cycle of a software clear still sets the flag.
        if (batt_set) begin
            low_batt_flag_d = 1'b1;
        end
        temperature_result_d = temp_fire ? temp_conv_code : temperature_result_q;
        last_temp_d = temp_fire ? temp_conv_code : last_temp_q;
        battery_result_d = batt_set ? batt_conv_code : battery_result_q;
        ext_voltage_result_d = ext_result_load ? ext_result_code : ext_voltage_result_q;
        temp_irq_d = temp_fire;
    end

    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                HK_ADDR_TEMP_RESULT: rdata_d = temperature_result_q;
                HK_ADDR_BATT_RESULT: rdata_d = battery_result_q;
                HK_ADDR_EXT_RESULT: rdata_d = ext_voltage_result_q;
                HK_ADDR_START: rdata_d = {6'h0, start_q};
                HK_ADDR_STROBE: rdata_d = {4'h0, strobe_q};
                HK_ADDR_DELTA: rdata_d = {2'h0, delta_q};
                HK_ADDR_BATT_THR: rdata_d = thr_q;
                HK_ADDR_PWR_ENABLE: rdata_d = {5'h0, low_batt_enable_q, 2'h0};
                HK_ADDR_PWR_FLAG: rdata_d = {5'h0, low_batt_flag_q, 2'h0};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            start_q <= 2'h0;
            strobe_q <= 4'h0;
            delta_q <= 6'h0;
            thr_q <= HK_RST_REG;
            low_batt_enable_q <= 1'b0;
            low_batt_flag_q <= 1'b0;
            temperature_result_q <= HK_RST_RESULT;
            last_temp_q <= HK_RST_RESULT;
            battery_result_q <= HK_RST_RESULT;
            ext_voltage_result_q <= HK_RST_RESULT;
            temp_irq_q <= 1'b0;
            rdata_q <= HK_RST_REG;
        end else begin
            start_q <= start_d;
            strobe_q <= strobe_d;
            delta_q <= delta_d;
            thr_q <= thr_d;
            low_batt_enable_q <= low_batt_enable_d;
            low_batt_flag_q <= low_batt_flag_d;
            temperature_result_q <= temperature_result_d;
            last_temp_q <= last_temp_d;
            battery_result_q <= battery_result_d;
            ext_voltage_result_q <= ext_voltage_result_d;
            temp_irq_q <= temp_irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign temp_irq = temp_irq_q;
    assign power_supply_monitor_irq = low_batt_flag_q & low_batt_enable_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_temp_single_done;
        fin[HK_CH_TEMP] && fin_single[HK_CH_TEMP];
    endsequence

    sequence s_batt_low_done;
        fin[HK_CH_BATT] && (batt_conv_code < thr_q);
    endsequence

    chk_single_temp_irq: assert property (s_temp_single_done |=> temp_irq &&
        temperature_result_q == $past(temp_conv_code)) else $error("single temp no irq");
    chk_temp_result_hold: assert property (!temp_fire |=>
        $stable(temperature_result_q)) else $error("temp result changed without irq");
    chk_batt_mode_no_bg: assert property ($rose(temp_conv_req) &&
        $past(power_mode) == HK_MODE_BATT |-> g_ch[HK_CH_TEMP].single_q)
        else $error("background temp in battery mode");
    chk_sleep_no_batt: assert property ($rose(batt_conv_req) |->
        $past(power_mode) != HK_MODE_SLEEP) else $error("battery conversion in sleep");
    chk_low_batt_set: assert property (s_batt_low_done |=> low_batt_flag_q &&
        battery_result_q == $past(batt_conv_code)) else $error("low battery not flagged");
    chk_power_irq_gate: assert property (!low_batt_enable_q |-> !power_supply_monitor_irq)
        else $error("power irq without enable");
    chk_start_self_clear: assert property (accept_single[HK_CH_TEMP] &&
        !(sfr_wr && sfr_addr == HK_ADDR_START) |=> !start_q[HK_CH_TEMP])
        else $error("start bit not cleared");
    chk_delta_zero_quiet: assert property (fin[HK_CH_TEMP] && !fin_single[HK_CH_TEMP] &&
        temp_delta_field == HK_DELTA_OFF |=> !temp_irq) else $error("irq with delta off");
    chk_batt_result_hold: assert property (!batt_set |=>
        $stable(battery_result_q)) else $error("battery result changed without flag");
    chk_interval_off: assert property (strobe_q[1:0] == 2'h0 ##1 strobe_q[1:0] == 2'h0
        |-> !sif.due[HK_CH_TEMP]) else $error("temp due with interval off");

endmodule
`default_nettype wire

//--- inc/hk_pkg.sv
// Constants, register map and types for the housekeeping converter control.
// Assumes one 40 MHz system clock and a byte-wide special function register port.
package hk_pkg;

    // Clock rate and the background scheduling base time.
    localparam longint HK_CLK_HZ = 40000000;
    localparam longint HK_MINUTE_S = 60;
    localparam logic [31:0] HK_MINUTE_CYCLES = 32'(HK_MINUTE_S * HK_CLK_HZ);

    // Register addresses on the special function register port.
    localparam logic [7:0] HK_ADDR_TEMP_RESULT = 8'hd7;
    localparam logic [7:0] HK_ADDR_START = 8'hd8;
    localparam logic [7:0] HK_ADDR_BATT_RESULT = 8'hdf;
    localparam logic [7:0] HK_ADDR_PWR_ENABLE = 8'hec;
    localparam logic [7:0] HK_ADDR_EXT_RESULT = 8'hef;
    localparam logic [7:0] HK_ADDR_DELTA = 8'hf3;
    localparam logic [7:0] HK_ADDR_PWR_FLAG = 8'hf8;
    localparam logic [7:0] HK_ADDR_STROBE = 8'hf9;
    localparam logic [7:0] HK_ADDR_BATT_THR = 8'hfa;

    // Field positions.
    localparam int HK_BIT_BATT_START = 0;
    localparam int HK_BIT_TEMP_START = 1;
    localparam int HK_BIT_LOW_BATT = 2;
    localparam int HK_TEMP_SEL_LSB = 0;
    localparam int HK_BATT_SEL_LSB = 2;
    localparam int HK_DELTA_LSB = 3;

    // Values after reset.
    localparam logic [7:0] HK_RST_RESULT = 8'h00;
    localparam logic [7:0] HK_RST_REG = 8'h00;

    // Delta field codes.
    localparam logic [2:0] HK_DELTA_OFF = 3'h0;
    localparam logic [2:0] HK_DELTA_ALL = 3'h7;

    // Background intervals in minutes for codes 01, 10 and 11.
    localparam logic [4:0] HK_TEMP_MIN_1 = 5'h08;
    localparam logic [4:0] HK_TEMP_MIN_2 = 5'h02;
    localparam logic [4:0] HK_TEMP_MIN_3 = 5'h01;
    localparam logic [4:0] HK_BATT_MIN_1 = 5'h10;
    localparam logic [4:0] HK_BATT_MIN_2 = 5'h04;
    localparam logic [4:0] HK_BATT_MIN_3 = 5'h01;

    // Channel indices.
    localparam int HK_CH_BATT = 0;
    localparam int HK_CH_TEMP = 1;

    typedef enum logic [1:0] {
        HK_MODE_FULL,
        HK_MODE_BATT,
        HK_MODE_SLEEP,
        HK_MODE_RSVD
    } hk_mode_t;

    typedef enum logic [1:0] {
        HK_IDLE,
        HK_REQ,
        HK_WAIT
    } hk_cstate_t;

endpackage

//--- inc/hk_sched_if.sv
// Link between the converter control and its background scheduler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface hk_sched_if;
    logic [1:0][1:0] sel;
    logic [1:0] due;
    modport ctrl (output sel, input due);
    modport sched (input sel, output due);
endinterface
`default_nettype wire

//--- hw/hk_sched.sv
// Background scheduler: a minute divider and one interval counter per channel.
// Assumes the interval selects are static registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hk_sched
    import hk_pkg::*;
#(
    parameter logic [31:0] MINUTE_CYCLES = HK_MINUTE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    hk_sched_if.sched sif
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] div_q;
    logic [31:0] div_d;
    logic tick;

    always_comb begin
        tick = (div_q == MINUTE_CYCLES - 32'h1);
        div_d = tick ? 32'h0 : div_q + 32'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] minutes(input int ch, input logic [1:0] sel);
        logic [4:0] m;
        m = 5'h0;
        case (sel)
            2'h1: m = (ch == HK_CH_TEMP) ? HK_TEMP_MIN_1 : HK_BATT_MIN_1;
            2'h2: m = (ch == HK_CH_TEMP) ? HK_TEMP_MIN_2 : HK_BATT_MIN_2;
            2'h3: m = (ch == HK_CH_TEMP) ? HK_TEMP_MIN_3 : HK_BATT_MIN_3;
            default: m = 5'h0;
        endcase
        return m;
    endfunction

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [4:0] min_q;
        logic [4:0] min_d;
        logic due_d;
        logic due_q;

        // A zero select clears the counter, but the divider runs on, so the first interval after an enable can be up to a minute short.
        always_comb begin
            min_d = min_q;
            due_d = 1'b0;
            if (sif.sel[c] == 2'h0) begin
                min_d = 5'h0;
            end else if (tick) begin
                if (min_q + 5'h1 >= minutes(c, sif.sel[c])) begin
                    min_d = 5'h0;
                    due_d = 1'b1;
                end else begin
                    min_d = min_q + 5'h1;
                end
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                min_q <= 5'h0;
                due_q <= 1'b0;
            end else begin
                min_q <= min_d;
                due_q <= due_d;
            end
        end

        assign sif.due[c] = due_q;
    end

endmodule
`default_nettype wire

//--- verif/hk_conv_model.sv
// Behavioural model of one housekeeping converter channel.
// Assumes the request is held until the acknowledge is seen at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hk_conv_model #(
    parameter int LAT = 2
) (
    input wire logic sys_clk,
    input wire logic req,
    input wire logic [7:0] next_code,
    output logic ack,
    output logic done,
    output logic [7:0] code
);
    initial begin
        ack = 1'b0;
        done = 1'b0;
        code = 8'h00;
        forever begin
            @(posedge sys_clk);
            #1;
            if (req === 1'b1) begin
                repeat (LAT) @(posedge sys_clk);
                #1 ack = 1'b1;
                @(posedge sys_clk);
                #1 ack = 1'b0;
                repeat (LAT) @(posedge sys_clk);
                #1 done = 1'b1;
                code = next_code;
                @(posedge sys_clk);
                // The code is valid only with done, so it is scrambled afterwards.
                #1 done = 1'b0;
                code = ~code;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the housekeeping converter control.
// Assumes a shortened minute of 20 cycles and two converter models.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hk_pkg::*;
    logic sys_clk, resetn, sfr_wr, sfr_rd, temp_irq, power_supply_monitor_irq, p_seen;
    logic [1:0] power_mode, r_seen;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, t_code, b_code, tc;
    logic batt_conv_req, batt_conv_ack, batt_conv_done, temp_conv_req, temp_conv_ack;
    logic temp_conv_done, ext_result_load;
    logic [7:0] batt_conv_code, temp_conv_code, ext_result_code;
    int error_cnt, n_tests;
    localparam logic [7:0] RA[10] = '{8'hd7, 8'hdf, 8'hef, 8'hd8, 8'hf9, 8'hf3, 8'hfa,
        8'hec, 8'hf8, 8'h10};

    hk_adc_ctrl #(.MINUTE_CYCLES(32'd20)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .power_mode(power_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .batt_conv_req(batt_conv_req),
        .batt_conv_ack(batt_conv_ack), .batt_conv_done(batt_conv_done),
        .batt_conv_code(batt_conv_code), .temp_conv_req(temp_conv_req),
        .temp_conv_ack(temp_conv_ack), .temp_conv_done(temp_conv_done),
        .temp_conv_code(temp_conv_code), .ext_result_load(ext_result_load),
        .ext_result_code(ext_result_code), .temp_irq(temp_irq),
        .power_supply_monitor_irq(power_supply_monitor_irq));
    // The battery side answers slowly, the temperature side promptly.
    hk_conv_model #(.LAT(4)) batt_u (.sys_clk(sys_clk), .req(batt_conv_req),
        .next_code(b_code), .ack(batt_conv_ack), .done(batt_conv_done),
        .code(batt_conv_code));
    hk_conv_model #(.LAT(1)) temp_u (.sys_clk(sys_clk), .req(temp_conv_req),
        .next_code(t_code), .ack(temp_conv_ack), .done(temp_conv_done),
        .code(temp_conv_code));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_rd = 1'b0;
        chk(what, exp, sfr_rdata);
    endtask

    // Counts temperature pulses and notes power interrupts and requests over n cycles.
    task automatic watch(input int n);
        tc = 8'h00;
        p_seen = 1'b0;
        r_seen = 2'h0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (temp_irq === 1'b1) tc++;
            if (power_supply_monitor_irq === 1'b1) p_seen = 1'b1;
            if (batt_conv_req === 1'b1) r_seen[0] = 1'b1;
            if (temp_conv_req === 1'b1) r_seen[1] = 1'b1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        foreach (RA[i]) rchk("reset value", RA[i], 8'h00);
        wr(HK_ADDR_TEMP_RESULT, 8'h5a);
        rchk("ro temp result", HK_ADDR_TEMP_RESULT, 8'h00);
        @(posedge sys_clk);
        #1 ext_result_code = 8'h3c;
        ext_result_load = 1'b1;
        @(posedge sys_clk);
        #1 ext_result_load = 1'b0;
        rchk("ext result", HK_ADDR_EXT_RESULT, 8'h3c);
        $display("reset test done");
    endtask

    task automatic t_temp;
        t_code = 8'h40;
        wr(HK_ADDR_START, 8'h02);
        watch(30);
        chk("single temp irqs", 8'h01, tc);
        rchk("temp result", HK_ADDR_TEMP_RESULT, 8'h40);
        rchk("start bits", HK_ADDR_START, 8'h00);
        // Delta of two steps: a change of two must stay quiet, three must interrupt.
        wr(HK_ADDR_DELTA, 8'h10);
        t_code = 8'h42;
        wr(HK_ADDR_STROBE, 8'h03);
        watch(70);
        chk("small change irqs", 8'h00, tc);
        rchk("temp result kept", HK_ADDR_TEMP_RESULT, 8'h40);
        t_code = 8'h43;
        watch(45);
        chk("large change irqs", 8'h01, tc);
        rchk("temp result new", HK_ADDR_TEMP_RESULT, 8'h43);
        wr(HK_ADDR_DELTA, 8'h38);
        watch(70);
        chk("every conv irqs", 8'h01, {7'h0, tc >= 8'd2});
        wr(HK_ADDR_STROBE, 8'h00);
        watch(20);
        wr(HK_ADDR_STROBE, 8'h01);
        watch(140);
        chk("8 min early", 8'h00, tc);
        watch(40);
        chk("8 min due", 8'h01, tc);
        wr(HK_ADDR_STROBE, 8'h00);
        watch(20);
        wr(HK_ADDR_STROBE, 8'h02);
        watch(100);
        chk("2 min irqs", 8'h02, tc);
        wr(HK_ADDR_STROBE, 8'h00);
        watch(20);
        $display("temperature test done");
    endtask

    task automatic t_batt;
        b_code = 8'h55;
        wr(HK_ADDR_START, 8'h01);
        watch(40);
        chk("masked power irq", 8'h00, {7'h0, p_seen});
        rchk("flag single", HK_ADDR_PWR_FLAG, 8'h04);
        rchk("batt result", HK_ADDR_BATT_RESULT, 8'h55);
        wr(HK_ADDR_PWR_ENABLE, 8'h04);
        watch(2);
        chk("power irq enabled", 8'h01, {7'h0, power_supply_monitor_irq});
        wr(HK_ADDR_PWR_FLAG, 8'h00);
        watch(2);
        chk("power irq cleared", 8'h00, {7'h0, power_supply_monitor_irq});
        wr(HK_ADDR_BATT_THR, 8'h80);
        b_code = 8'h90;
        wr(HK_ADDR_STROBE, 8'h0c);
        watch(70);
        chk("above thr power irq", 8'h00, {7'h0, p_seen});
        rchk("batt result kept", HK_ADDR_BATT_RESULT, 8'h55);
        b_code = 8'h70;
        watch(40);
        chk("below thr power irq", 8'h01, {7'h0, p_seen});
        rchk("batt result low", HK_ADDR_BATT_RESULT, 8'h70);
        wr(HK_ADDR_STROBE, 8'h00);
        watch(30);
        wr(HK_ADDR_PWR_FLAG, 8'h00);
        $display("battery test done");
    endtask

    task automatic t_modes;
        // A full threshold flags any battery conversion that slips through.
        wr(HK_ADDR_BATT_THR, 8'hff);
        power_mode = 2'd2;
        wr(HK_ADDR_START, 8'h03);
        wr(HK_ADDR_STROBE, 8'h0f);
        watch(70);
        chk("sleep temp bg", 8'h01, {7'h0, tc >= 8'd2});
        chk("sleep batt", 8'h00, {7'h0, p_seen});
        chk("sleep batt req", 8'h00, {7'h0, r_seen[0]});
        rchk("sleep starts held", HK_ADDR_START, 8'h03);
        wr(HK_ADDR_STROBE, 8'h00);
        watch(20);
        power_mode = 2'd1;
        wr(HK_ADDR_STROBE, 8'h0f);
        watch(40);
        chk("active singles", 8'h01, tc);
        chk("active batt single", 8'h01, {7'h0, p_seen});
        wr(HK_ADDR_PWR_FLAG, 8'h00);
        watch(70);
        chk("active temp bg", 8'h00, tc);
        chk("active batt bg", 8'h00, {7'h0, p_seen});
        chk("active bg reqs", 8'h00, {6'h0, r_seen});
        power_mode = 2'd0;
        watch(70);
        chk("full temp bg", 8'h01, {7'h0, tc >= 8'd2});
        chk("full batt bg", 8'h01, {7'h0, p_seen});
        wr(HK_ADDR_DELTA, 8'h00);
        watch(50);
        chk("delta off irqs", 8'h00, tc);
        $display("mode test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        resetn = 1'b0;
        power_mode = 2'd0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        ext_result_load = 1'b0;
        ext_result_code = 8'h00;
        t_code = 8'h00;
        b_code = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        t_reset();
        t_temp();
        t_batt();
        t_modes();
        conclude();
    end

    // The tests need about 1150 cycles; this limit leaves ample margin.
    initial begin
        #(20000 * 25);
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
